// file: logic/mds_pkg.sv
// shared constants for the micro dma start select and external irq block
package mds_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  SEL1_IDX     = 8'h5B;
    localparam logic [7:0]  SEL2_IDX     = 8'h5C;
    localparam logic [7:0]  SEL3_IDX     = 8'h5D;
    localparam logic [7:0]  IMODE_IDX    = 8'h60;
    localparam logic [7:0]  CAPMODE_IDX  = 8'h61;
    localparam logic [7:0]  STATUS_IDX   = 8'h62;
    localparam logic [7:0]  MASK_IDX     = 8'h63;
    localparam logic [7:0]  FLAGS_IDX    = 8'h64;
    localparam int          ADDR_W       = 12;
    // field positions
    localparam int          IMODE_NMI_BOTH = 0;
    localparam int          IMODE_PIN0_LVL = 1;
    localparam int          CAP_A_LSB      = 0;
    localparam int          CAP_B_LSB      = 2;
    localparam logic [1:0]  CAP_FALLING    = 2'h2;
    // vector codes: source i carries VEC_BASE + VEC_STEP * i
    localparam int          NUM_SRC      = 30;
    localparam int          NUM_PINS     = 9;
    localparam int          NUM_PERIPH   = NUM_SRC - NUM_PINS;
    localparam logic [7:0]  VEC_BASE     = 8'h28;
    localparam logic [7:0]  VEC_STEP     = 8'h04;
    localparam logic [7:0]  VEC_SOFT     = 8'hFC;
    // status layout: nmi, pins 0..8, transfer end 1..3
    localparam int          ST_W         = 13;
    localparam int          ST_XFER_LSB  = 10;
    // reset values and axi response codes
    localparam logic [7:0]  SEL_RST      = 8'h00;
    localparam logic [1:0]  IMODE_RST    = 2'h0;
    localparam logic [3:0]  CAP_RST      = 4'h0;
    localparam logic [9:0]  SYNC_RST     = 10'h001;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : mds_pkg

// file: logic/mds_top.sv
// start source selection for dma channels 1..3 and external irq sensing
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps

// Summary of operation
// [R1] write-only selectors for channels 1-3, reset zero
// [R2] software uses plain writes, never read-modify-write
// [R3] fixed vector codes 28H to 9CH step four
// [R4] code FCH gives a software dma start
// [R5] nmi falling edge, or both edges when set
// [R6] other pins sense rising edges
// [R7] pin 5 falling when capture mode a is 10
// [R8] pin 7 falling when capture mode b is 10
// [R9] input mode register controls nmi and pin 0
// [R10] matching source is routed to dma, not cpu
// [R11] lowest channel wins on equal selector codes
// [R12] count zero raises end irq; zero selector releases
// [R13] compare bits 7 to 2 only
// [R14] pins synchronised, one-cycle detect sets request flag
module mds_top (
    input  wire logic                         clock,
    input  wire logic                         reset,
    input  wire logic [mds_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [mds_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         nmiPinN,
    input  wire logic [mds_pkg::NUM_PINS-1:0] extIrqPin,
    input  wire logic [mds_pkg::NUM_PERIPH-1:0] periphIrq,
    input  wire logic [mds_pkg::NUM_SRC-1:0]  cpuClear,
    input  wire logic [3:1]                   dmaAck,
    input  wire logic [3:1]                   xferCountZero,
    output logic [mds_pkg::NUM_SRC-1:0]       cpuIrqReq,
    output logic                              nmiReq,
    output logic [3:1]                        dmaReq,
    output logic [3:1]                        dmaSoftStart,
    output logic [3:1]                        transferEndIrq,
    output logic                              irq
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte address of a register index
    function automatic logic [mds_pkg::ADDR_W-1:0] regAddr(
        input logic [7:0] idx
    );
        regAddr = {2'h0, idx, 2'h0};
    endfunction : regAddr

    // vector code of hardware source i
    function automatic logic [7:0] vecCode(input int i);
        vecCode = mds_pkg::VEC_BASE + 8'(mds_pkg::VEC_STEP * i); // [R3]
    endfunction : vecCode

    // compare the upper six bits only; low two bits are don't care
    function automatic logic codeMatch(
        input logic [7:0] a,
        input logic [7:0] b
    );
        codeMatch = (a[7:2] == b[7:2]); // [R13]
    endfunction : codeMatch

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]                   sel_q [1:3];
    logic [1:0]                   imode_q;
    logic [3:0]                   capMode_q;
    logic [mds_pkg::ST_W-1:0]     status_q;
    logic [mds_pkg::ST_W-1:0]     mask_q;
    logic [mds_pkg::NUM_SRC-1:0]  flags_q;
    logic [9:0]                   sync1_q;
    logic [9:0]                   sync2_q;
    logic [9:0]                   sync3_q;
    logic [9:0]                   lvl_q;
    logic [9:0]                   lvl_d;
    logic [9:0]                   detect_q;
    logic [9:0]                   detect_d;

    // axi write side
    logic                         awHeld_q;
    logic                         wHeld_q;
    logic [mds_pkg::ADDR_W-1:0]   wAddr_q;
    logic [31:0]                  wData_q;
    logic                         wByte0_q;
    logic                         wrEn;
    logic                         wrHit;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            wAddr_q       <= '0;
            wData_q       <= '0;
            wByte0_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= mds_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q      <= 1'b1;
                wAddr_q       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q      <= 1'b1;
                wData_q      <= s_axi_wdata;
                wByte0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wrEn) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? mds_pkg::RESP_OKAY
                                      : mds_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // the write lands once both halves are held
    assign wrEn = awHeld_q && wHeld_q && !s_axi_bvalid;

    // decode of the held write address
    always_comb begin
        wrHit = 1'b0;
        // indices 5B..63 are mapped; the gap 5E/5F is removed below
        for (int k = 0; k < 9; k++) begin
            if (wAddr_q == regAddr(mds_pkg::SEL1_IDX + 8'(k)))
                wrHit = 1'b1;
        end
        if (wAddr_q == regAddr(mds_pkg::SEL3_IDX + 8'h01) ||
            wAddr_q == regAddr(mds_pkg::SEL3_IDX + 8'h02)) begin
            wrHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start source selectors; bits 1:0 stored as zero and never read back

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int c = 1; c <= 3; c++) sel_q[c] <= mds_pkg::SEL_RST; // [R1]
            dmaSoftStart <= '0;
        end else begin
            dmaSoftStart <= '0;
            for (int c = 1; c <= 3; c++) begin
                if (wrEn && wByte0_q && wAddr_q ==
                    regAddr(mds_pkg::SEL1_IDX + 8'(c - 1))) begin
                    sel_q[c] <= {wData_q[7:2], 2'h0}; // [R1] [R13]
                    // soft code starts the channel once, no source involved
                    if (codeMatch(wData_q[7:0], mds_pkg::VEC_SOFT))
                        dmaSoftStart[c] <= 1'b1; // [R4]
                end
            end
        end
    end

    // mode, capture, mask and status registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            imode_q   <= mds_pkg::IMODE_RST;
            capMode_q <= mds_pkg::CAP_RST;
            mask_q    <= '0;
            status_q  <= '0;
        end else begin
            if (wrEn && wByte0_q && wAddr_q == regAddr(mds_pkg::IMODE_IDX))
                imode_q <= wData_q[1:0]; // [R9]
            if (wrEn && wByte0_q && wAddr_q == regAddr(mds_pkg::CAPMODE_IDX))
                capMode_q <= wData_q[3:0];
            if (wrEn && wAddr_q == regAddr(mds_pkg::MASK_IDX))
                mask_q <= wData_q[mds_pkg::ST_W-1:0];
            // set wins over a write-one clear in the same cycle
            status_q <= (status_q & ~((wrEn && wAddr_q ==
                         regAddr(mds_pkg::STATUS_IDX)) ?
                         wData_q[mds_pkg::ST_W-1:0] : '0))
                      | {xferCountZero, detect_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel, data one cycle after the address

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= mds_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mds_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
            case (s_axi_araddr)
                // selectors are write-only and read as zero
                regAddr(mds_pkg::SEL1_IDX),
                regAddr(mds_pkg::SEL2_IDX),
                regAddr(mds_pkg::SEL3_IDX):    s_axi_rdata <= '0;
                regAddr(mds_pkg::IMODE_IDX):   s_axi_rdata <= {30'h0, imode_q};
                regAddr(mds_pkg::CAPMODE_IDX): s_axi_rdata <= {28'h0, capMode_q};
                regAddr(mds_pkg::STATUS_IDX):  s_axi_rdata <= {19'h0, status_q};
                regAddr(mds_pkg::MASK_IDX):    s_axi_rdata <= {19'h0, mask_q};
                regAddr(mds_pkg::FLAGS_IDX):   s_axi_rdata <= {2'h0, flags_q};
                default:                       s_axi_rresp <= mds_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: bit 0 nmi (active low), bits 1..9 pins 0..8

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_q  <= mds_pkg::SYNC_RST;
            sync2_q  <= mds_pkg::SYNC_RST;
            sync3_q  <= mds_pkg::SYNC_RST;
            lvl_q    <= mds_pkg::SYNC_RST;
            detect_q <= '0;
        end else begin
            sync1_q  <= {extIrqPin, nmiPinN}; // [R14]
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            lvl_q    <= lvl_d;
            detect_q <= detect_d; // [R14]
        end
    end

    // accepted level moves only when the second and third stages agree,
    // which filters a single-cycle glitch on the pin
    always_comb begin
        logic [9:0] rise;
        logic [9:0] fall;
        rise = '0;
        fall = '0;
        for (int i = 0; i < 10; i++)
            lvl_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : lvl_q[i];
        rise = lvl_d & ~lvl_q;
        fall = ~lvl_d & lvl_q;
        detect_d = rise;                                    // [R6]
        detect_d[0] = fall[0] |
                      (imode_q[mds_pkg::IMODE_NMI_BOTH] & rise[0]); // [R5] [R9]
        if (capMode_q[mds_pkg::CAP_A_LSB +: 2] == mds_pkg::CAP_FALLING)
            detect_d[6] = fall[6];                          // [R7]
        if (capMode_q[mds_pkg::CAP_B_LSB +: 2] == mds_pkg::CAP_FALLING)
            detect_d[8] = fall[8];                          // [R8]
        if (imode_q[mds_pkg::IMODE_PIN0_LVL])
            detect_d[1] = 1'b0;                             // [R9]
    end

    ////////////////////////////////////////////////////////////////////////
    // request flags and routing to dma or cpu

    logic [1:0]                   route [mds_pkg::NUM_SRC];
    logic [mds_pkg::NUM_SRC-1:0]  dmaClr;
    logic [mds_pkg::NUM_SRC-1:0]  toCpu;
    logic [3:1]                   toDma;

    // lowest channel checked last so it overrides higher ones
    always_comb begin
        dmaClr = '0;
        toCpu  = '0;
        toDma  = '0;
        for (int i = 0; i < mds_pkg::NUM_SRC; i++) begin
            route[i] = 2'h0;
            for (int c = 3; c >= 1; c--) begin
                // a zero selector never matches, so clearing releases it
                if (sel_q[c] != 8'h00 && codeMatch(sel_q[c], vecCode(i)))
                    route[i] = 2'(c); // [R10] [R11] [R12]
            end
            if (route[i] == 2'h0) begin
                toCpu[i] = flags_q[i];
            end else begin
                toDma[route[i]] = toDma[route[i]] | flags_q[i]; // [R10]
                dmaClr[i] = dmaAck[route[i]];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flags_q <= '0;
        end else begin
            // a new request beats a clear arriving in the same cycle
            flags_q <= (flags_q & ~(cpuClear | dmaClr)) |
                       {periphIrq, detect_q[9:1]}; // [R14]
            if (imode_q[mds_pkg::IMODE_PIN0_LVL])
                flags_q[0] <= lvl_q[1]; // [R9]
        end
    end

    // registered outputs toward cpu and dma engine
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cpuIrqReq      <= '0;
            dmaReq         <= '0;
            nmiReq         <= 1'b0;
            transferEndIrq <= '0;
            irq            <= 1'b0;
        end else begin
            cpuIrqReq      <= toCpu;  // [R10]
            dmaReq         <= toDma;  // [R10]
            nmiReq         <= detect_q[0];
            transferEndIrq <= xferCountZero; // [R12]
            irq            <= |(status_q & mask_q);
        end
    end

endmodule : mds_top

// file: verification/mds_chk.sv
// port checker for the dma start select block
`timescale 1ns/10ps
module mds_chk (
    input wire logic                       clock,
    input wire logic                       reset,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic [1:0]                 s_axi_bresp,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic [mds_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    input wire logic                       nmiPinN,
    input wire logic                       nmiReq,
    input wire logic [3:1]                 dmaSoftStart,
    input wire logic [3:1]                 xferCountZero,
    input wire logic [3:1]                 transferEndIrq
);
    logic [3:0] quietCnt_q;
    logic       nmiPrev_q;
    ////////////////////////////////////////////////////////////////////////
    // cycles since the nmi pin moved; saturates so a long idle never wraps
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quietCnt_q <= 4'h0;
            nmiPrev_q  <= 1'b1;
        end else begin
            nmiPrev_q <= nmiPinN;
            if (nmiPinN != nmiPrev_q) quietCnt_q <= 4'h0;
            else if (quietCnt_q != 4'hF) quietCnt_q <= quietCnt_q + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // end-of-count pulse comes out exactly one cycle later
    endIrqDelay_a: assert property (
        1'b1 |=> transferEndIrq == $past(xferCountZero))
        else $error("transfer end pulse not one cycle after count zero");
    nmiPulse_a: assert property (nmiReq |=> !nmiReq)
        else $error("nmi detect wider than one cycle");
    softPulse_a: assert property (|dmaSoftStart |=> ~|dmaSoftStart)
        else $error("soft start wider than one cycle");
    // the nmi pin cannot raise a detect once it has stood still long enough
    nmiQuiet_a: assert property (quietCnt_q >= 4'hA |-> !nmiReq)
        else $error("nmi detect without a pin edge");
    writeResp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("no write response after address and data");
    respHold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    readHold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    addrBlock_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("new write taken before response");
    // selectors are write-only, so reads must come back empty
    selReadZero_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h16C
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("selector readback not zero");
endmodule : mds_chk
bind mds_top mds_chk mds_chk_inst (.*);

// file: verification/mds_dma_model.sv
// dma engine stand-in that accepts routed requests after a set delay
`timescale 1ns/10ps
module mds_dma_model (
    input wire logic       clock,
    input wire logic       reset,
    input wire logic [7:0] ackDelay,
    input wire logic [3:1] dmaReq,
    output logic     [3:1] dmaAck
);
    int waitCnt [3:1];
    // each channel acks once when its request has aged ackDelay cycles
    always @(posedge clock or posedge reset) begin
        for (int c = 1; c <= 3; c++) begin
            if (reset || !dmaReq[c] || dmaAck[c]) begin
                waitCnt[c] <= 0;
                dmaAck[c]  <= 1'b0;
            end else if (waitCnt[c] >= ackDelay) begin
                dmaAck[c] <= 1'b1;
            end else begin
                waitCnt[c] <= waitCnt[c] + 1;
            end
        end
    end
endmodule : mds_dma_model

// file: verification/testbench.sv
// self-checking bench for the dma start select block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    logic clock = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, nmiReq, irq, lookReq = 0, nmiPinN = 1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [8:0]  extIrqPin = 0;
    logic [20:0] periphIrq = 0;
    logic [29:0] cpuClear = 0, cpuIrqReq;
    logic [3:1]  dmaAck, xferCountZero = 0, dmaReq, dmaSoftStart;
    logic [3:1]  transferEndIrq;
    logic [7:0]  ackDelay = 8'h28;
    logic [33:0] rq[$], bq[$], lq[$], sq[$], eq[$], nq[$];
    int n_errors = 0, compares = 0, j;
    mds_top mds_top_inst (.*);
    mds_dma_model mds_dma_model_inst (.*);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    // whole-word write; response is waited for, never assumed
    task automatic wr(input logic [7:0] ix, input logic [31:0] d,
                      input logic [1:0] rsp = 2'h0);
        bq.push_back({32'h0, rsp});
        s_axi_awaddr  <= {2'b00, ix, 2'b00};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] ix, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr  <= {2'b00, ix, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : rd
    // note expected {irq, dmaReq, cpuIrqReq}, sampled at the next edge
    task automatic look(input logic [33:0] e);
        lq.push_back(e);
        lookReq <= 1'b1;
        @(posedge clock);
        lookReq <= 1'b0;
    endtask : look
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // monitor takes the oldest note as each result shows up
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready)
            `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
        if (s_axi_bvalid && s_axi_bready)
            `CHK({32'h0, s_axi_bresp}, bq.pop_front())
        if (lookReq) `CHK({irq, dmaReq, cpuIrqReq}, lq.pop_front())
        if (nmiReq) `CHK({33'h0, nmiReq}, nq.pop_front())
        if (|dmaSoftStart) `CHK({31'h0, dmaSoftStart}, sq.pop_front())
        if (|transferEndIrq)
            `CHK({31'h0, transferEndIrq}, eq.pop_front())
    end
    // watchdog: the tests need a few thousand cycles at most
    initial begin
        #400_000;
        n_errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        j = $urandom(49305);
        wt(6);
        reset <= 1'b0;
        wt(1);
        rd(mds_pkg::SEL1_IDX, 34'h0);
        rd(8'h7F, {mds_pkg::RESP_SLVERR, 32'h0});
        wr(8'h7F, 32'h1, mds_pkg::RESP_SLVERR);
        $display("test bus done");
        // every pin senses a rising edge and nothing on the fall
        for (int p = 0; p < 9; p++) begin
            extIrqPin[p] <= 1'b1;
            wt(10);
            look({4'h0, 30'(1) << p});
            rd(mds_pkg::STATUS_IDX, 34'(1) << (p + 1));
            wr(mds_pkg::STATUS_IDX, 32'h0000_1FFF);
            cpuClear <= 30'(1) << p;
            wt(1);
            cpuClear <= 30'h0;
        end
        extIrqPin <= 9'h0;
        wt(10);
        rd(mds_pkg::STATUS_IDX, 34'h0);
        $display("test pins done");
        // pins 5 and 7 fall-sense only for capture mode 10
        for (int m = 0; m < 4; m++) begin
            wr(mds_pkg::CAPMODE_IDX, {28'h0, m[1:0], m[1:0]});
            for (int lv = 1; lv >= 0; lv--) begin
                extIrqPin[5] <= lv[0];
                extIrqPin[7] <= lv[0];
                wt(10);
                rd(mds_pkg::STATUS_IDX,
                   ((m == 2) ^ lv[0]) ? 34'h140 : 0);
                wr(mds_pkg::STATUS_IDX, 32'h0000_1FFF);
            end
        end
        cpuClear <= '1;
        wt(1);
        cpuClear <= 30'h0;
        $display("test capture done");
        // nmi: falling only, then both edges
        for (int b = 0; b < 2; b++) begin
            wr(mds_pkg::IMODE_IDX, b);
            for (int lv = 0; lv < 2; lv++) begin
                if (lv == 0 || b == 1) nq.push_back(34'h1);
                nmiPinN <= lv[0];
                wt(10);
                rd(mds_pkg::STATUS_IDX, (lv == 0 || b == 1) ? 34'h1 : 0);
                wr(mds_pkg::STATUS_IDX, 32'h0000_0001);
            end
        end
        $display("test nmi done");
        // shared code goes to channel 1; low bits are ignored
        wr(mds_pkg::SEL1_IDX, 32'h0000_0033);
        wr(mds_pkg::SEL2_IDX, 32'h0000_0030);
        extIrqPin[2] <= 1'b1;
        wt(10);
        look({4'h1, 30'h0});
        wt(50);
        look(34'h0);
        j = 9 + $urandom_range(20);
        wr(mds_pkg::SEL3_IDX, 32'(mds_pkg::VEC_BASE) + 32'(4 * j));
        for (int r = 0; r < 2; r++) begin
            periphIrq[j - 9] <= 1'b1;
            wt(1);
            periphIrq[j - 9] <= 1'b0;
            wt(4);
            look(r == 0 ? {4'h4, 30'h0} : {4'h0, 30'(1) << j});
            wt(50);
            wr(mds_pkg::SEL3_IDX, 32'h0);
        end
        $display("test routing done");
        // soft start, end-of-count irq with mask and clear
        sq.push_back(34'h2);
        wr(mds_pkg::SEL2_IDX, 32'(mds_pkg::VEC_SOFT));
        wr(mds_pkg::MASK_IDX, 32'h0000_0800);
        eq.push_back(34'h2);
        xferCountZero[2] <= 1'b1;
        wt(1);
        xferCountZero[2] <= 1'b0;
        wt(3);
        look({1'b1, 3'h0, 30'(1) << j});
        wr(mds_pkg::MASK_IDX, 32'h0);
        look({4'h0, 30'(1) << j});
        wr(mds_pkg::STATUS_IDX, 32'h0000_0800);
        // pin 0 in level mode: flag follows the pin, no status detect
        wr(mds_pkg::IMODE_IDX, 32'h0000_0002);
        extIrqPin[0] <= 1'b1;
        wt(10);
        look({4'h0, (30'(1) << j) | 30'h1});
        extIrqPin[0] <= 1'b0;
        wt(10);
        look({4'h0, 30'(1) << j});
        // only the pin 2 detect from the routing test is left pending
        rd(mds_pkg::STATUS_IDX, 34'h8);
        `CHK(34'(sq.size() + eq.size() + lq.size() + nq.size()), 34'h0)
        $display("test soft start and end irq done");
        final_report();
    end
endmodule : testbench
